//--- hdl/can_regs_defines.svh
// Register offsets, field positions, reset values for the controller register block.
// Assumes an 8-bit register port with byte addresses.
`ifndef CAN_REGS_DEFINES_SVH
`define CAN_REGS_DEFINES_SVH
`define ADDR_MODE        8'h00
`define ADDR_CMD         8'h01
`define ADDR_STATUS      8'h02
`define ADDR_IRQ_FLAGS   8'h03
`define ADDR_IRQ_EN      8'h04
`define ADDR_RX_THRESH   8'h05
`define ADDR_BT_PRESCALE 8'h06
`define ADDR_BT_SEGMENTS 8'h07
`define ADDR_RESERVED    8'h08
`define ADDR_WARN_LIMIT  8'h0D
`define ADDR_IRQ_CLEAR   8'h10
`define ADDR_IRQ_MASK    8'h11
`define ADDR_IRQ_STATUS  8'h12
`define ADDR_FIFO_FIRST  8'h80
`define ADDR_FIFO_LAST   8'hBF
`define MODE_RESET_BIT   0
`define MODE_LISTEN_BIT  1
`define MODE_SELFT_BIT   2
`define MODE_PULSE_BIT   6
`define MODE_HW_RESET    8'h01
`define MODE_SW_KEEP     8'h46
`define STATUS_HW_RESET  8'h3C
`define STATUS_SW_KEEP   8'h04
`define IRQ_SW_KEEP      8'h84
`define WARN_LIMIT_RESET 8'h60
`define EV_ENTER_RESET   0
`define EV_LEAVE_RESET   1
`define EV_ABORT         2
`endif

//--- hdl/can_regs_pkg.sv
// Types shared by the controller register block.
// Assumes the defines header supplies all numbers.
package can_regs_pkg;
    typedef struct packed {
        logic       test_mode_bit;
        logic       rx_irq_pulse_mode;
        logic       rx_pin_polarity;
        logic       sleep_mode_bit;
        logic       reserved_bit;
        logic       self_test_mode;
        logic       listen_only_mode;
        logic       reset_mode_bit;
    } mode_t;
    typedef struct packed {
        logic       bus_error_irq;
        logic       arb_loss_irq;
        logic       error_passive_irq;
        logic       wake_irq;
        logic       overrun_irq;
        logic       error_warning_irq;
        logic       tx_done_irq;
        logic       rx_frame_irq;
    } irq_t;
    typedef enum logic [1:0] {
        OP_RUN   = 2'b00,
        OP_RESET = 2'b01
    } op_state_t;
endpackage : can_regs_pkg

//--- hdl/can_reset_mode_regs.sv
// Register file and reset-mode control of a CAN controller.
// Assumes a same-clock register port; core events arrive as one-cycle pulses on MCLK.
`timescale 1ns/1ps
`include "can_regs_defines.svh"
// Overview of operation
// - A set reset-mode bit aborts any frame in progress and enters reset mode.
// - Reset-mode bit falling to zero leaves reset and resumes the selected mode.
// - Hardware reset clears mode bits, keeps pulse bit, sets reset-mode bit.
// - Software or bus-off reset clears test, polarity, sleep; keeps pulse, self-test, listen-only.
// - Command register always reads zero; its bits act only as strobes.
// - Hardware reset: status bus-on, no error, idle, complete, buffer released.
// - Software or bus-off reset clears status except transmit-buffer-released.
// - Hardware reset clears all eight interrupt flags.
// - Software or bus-off reset keeps bus-error and error-warning flags, clears others.
// - Interrupt enables follow flag positions; no reset changes them.
// - Timing register 0 holds jump width and prescaler; resets leave it.
// - Timing register 1 holds sampling, second and first segments; resets leave it.
// - Receive RAM 128 to 191 readable always, writable only in reset mode.
// - Window locations past the current message expose following RAM.
// - Trailing locations may hold old fragments; content after power-up undefined.
// - Address 8 is reserved; access has no effect.
// - Hardware reset loads warning limit 96; other resets leave it.
module can_reset_mode_regs #(
    parameter int FIFO_DEPTH = 64
) (
    input  wire logic       MCLK,
    input  wire logic       RST,
    input  wire logic [7:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       BUS_OFF,
    input  wire logic [7:0] STATUS_SET,
    input  wire logic [7:0] STATUS_CLR,
    input  wire logic [7:0] IRQ_EVENTS,
    input  wire logic       FIFO_WE,
    input  wire logic [5:0] FIFO_WADDR,
    input  wire logic [7:0] FIFO_WDATA,
    input  wire logic [5:0] RX_START,
    output logic            IN_RESET,
    output logic            ABORT_FRAME,
    output logic      [4:0] CMD_PULSE,
    output logic      [7:0] MODE_OUT,
    output logic      [7:0] TIMING0,
    output logic      [7:0] TIMING1,
    output logic      [7:0] WARN_LIMIT,
    output logic      [7:0] RX_THRESHOLD,
    output logic            CAN_IRQ,
    output logic            IRQ
);
    // Window decode is fixed at 128 to 191, so only a 64-byte RAM fits
    if (FIFO_DEPTH != 64) begin : g_bad_depth
        $error("FIFO_DEPTH must be 64");
    end

    can_regs_pkg::mode_t     mode;
    can_regs_pkg::irq_t      flags;
    can_regs_pkg::op_state_t state;
    logic [7:0] status;
    logic [7:0] irq_en;
    logic [7:0] ev_status;
    logic [7:0] ev_mask;
    logic [7:0] fifo_ram [0:FIFO_DEPTH-1];
    logic       wr_mode;
    logic       sw_reset;
    logic       in_fifo;
    logic [5:0] fifo_idx;
    logic [2:0] events;

    assign wr_mode  = WR && ADDR == `ADDR_MODE;
    // Software write of the bit or bus-off both enter reset mode
    assign sw_reset = (wr_mode && WDATA[`MODE_RESET_BIT] && !mode.reset_mode_bit) || BUS_OFF;
    assign in_fifo  = ADDR >= `ADDR_FIFO_FIRST && ADDR <= `ADDR_FIFO_LAST;
    // Window addressing is relative to the current message start
    assign fifo_idx = 6'(ADDR[5:0] + RX_START);

    always_ff @(posedge MCLK) begin
        if (RST) begin
            mode <= `MODE_HW_RESET | (mode & 8'h40);
        end else if (BUS_OFF) begin
            mode <= (mode & `MODE_SW_KEEP) | `MODE_HW_RESET;
        end else if (wr_mode) begin
            if (WDATA[`MODE_RESET_BIT] && !mode.reset_mode_bit) begin
                mode <= (mode & `MODE_SW_KEEP) | `MODE_HW_RESET;
            end else if (mode.reset_mode_bit) begin
                // Reserved bit 3 always reads zero
                mode <= WDATA & 8'hF7;
            end else begin
                // Listen-only and self-test only change in reset mode
                mode <= (WDATA & 8'hF1) | (mode & 8'h06);
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            state <= can_regs_pkg::OP_RESET;
        end else if (mode.reset_mode_bit || sw_reset) begin
            state <= can_regs_pkg::OP_RESET;
        end else begin
            state <= can_regs_pkg::OP_RUN;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ABORT_FRAME <= 1'b0;
        end else begin
            ABORT_FRAME <= sw_reset && state == can_regs_pkg::OP_RUN;
        end
    end

    // Command bits are strobes only, never stored, and ignored in reset mode
    always_ff @(posedge MCLK) begin
        if (RST || sw_reset) begin
            CMD_PULSE <= 5'h0_0;
        end else if (WR && ADDR == `ADDR_CMD && !mode.reset_mode_bit) begin
            CMD_PULSE <= WDATA[4:0];
        end else begin
            CMD_PULSE <= 5'h0_0;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            status <= `STATUS_HW_RESET;
        end else if (sw_reset) begin
            status <= status & `STATUS_SW_KEEP;
        end else begin
            // Set wins over clear
            status <= (status & ~STATUS_CLR) | STATUS_SET;
        end
    end

    // Reading the flag register clears it; a new event in that cycle survives
    always_ff @(posedge MCLK) begin
        if (RST) begin
            flags <= 8'h0_0;
        end else if (sw_reset) begin
            flags <= (flags & `IRQ_SW_KEEP) | (IRQ_EVENTS & `IRQ_SW_KEEP);
        end else if (RD && ADDR == `ADDR_IRQ_FLAGS) begin
            flags <= IRQ_EVENTS & irq_en;
        end else begin
            flags <= flags | (IRQ_EVENTS & irq_en);
        end
    end

    // Enables and timing hold through every reset kind
    always_ff @(posedge MCLK) begin
        if (WR && ADDR == `ADDR_IRQ_EN) begin
            irq_en <= WDATA;
        end
    end

    always_ff @(posedge MCLK) begin
        if (WR && ADDR == `ADDR_BT_PRESCALE && mode.reset_mode_bit) begin
            TIMING0 <= WDATA;
        end
    end

    always_ff @(posedge MCLK) begin
        if (WR && ADDR == `ADDR_BT_SEGMENTS && mode.reset_mode_bit) begin
            TIMING1 <= WDATA;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            RX_THRESHOLD <= 8'h0_0;
        end else if (WR && ADDR == `ADDR_RX_THRESH && mode.reset_mode_bit) begin
            RX_THRESHOLD <= WDATA;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            WARN_LIMIT <= `WARN_LIMIT_RESET;
        end else if (WR && ADDR == `ADDR_WARN_LIMIT && mode.reset_mode_bit) begin
            WARN_LIMIT <= WDATA;
        end
    end

    // RAM has no reset: old fragments stay visible
    always_ff @(posedge MCLK) begin
        if (WR && in_fifo && mode.reset_mode_bit) begin
            fifo_ram[ADDR[5:0]] <= WDATA;
        end else if (FIFO_WE) begin
            fifo_ram[FIFO_WADDR] <= FIFO_WDATA;
        end
    end

    // Block-level interrupt wrapper events
    assign events = {sw_reset && state == can_regs_pkg::OP_RUN,
                     state == can_regs_pkg::OP_RESET && !mode.reset_mode_bit,
                     sw_reset};

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ev_status <= 8'h0_0;
        end else begin
            ev_status <= (ev_status & ~((WR && ADDR == `ADDR_IRQ_CLEAR) ? WDATA : 8'h0_0))
                         | {5'h0_0, events};
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            ev_mask <= 8'h0_0;
        end else if (WR && ADDR == `ADDR_IRQ_MASK) begin
            ev_mask <= WDATA;
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            RDATA <= 8'h0_0;
        end else if (RD) begin
            if (in_fifo) begin
                RDATA <= mode.reset_mode_bit ? fifo_ram[ADDR[5:0]] : fifo_ram[fifo_idx];
            end else begin
                unique case (ADDR)
                    `ADDR_MODE:        RDATA <= mode;
                    `ADDR_STATUS:      RDATA <= status;
                    `ADDR_IRQ_FLAGS:   RDATA <= flags;
                    `ADDR_IRQ_EN:      RDATA <= irq_en;
                    `ADDR_RX_THRESH:   RDATA <= RX_THRESHOLD;
                    `ADDR_BT_PRESCALE: RDATA <= TIMING0;
                    `ADDR_BT_SEGMENTS: RDATA <= TIMING1;
                    `ADDR_WARN_LIMIT:  RDATA <= WARN_LIMIT;
                    `ADDR_IRQ_MASK:    RDATA <= ev_mask;
                    `ADDR_IRQ_STATUS:  RDATA <= ev_status;
                    default:           RDATA <= 8'h0_0;
                endcase
            end
        end else begin
            RDATA <= 8'h0_0;
        end
    end

    assign IN_RESET = state == can_regs_pkg::OP_RESET;
    assign MODE_OUT = mode;
    assign CAN_IRQ  = |flags;
    assign IRQ      = |(ev_status & ev_mask);
endmodule : can_reset_mode_regs

//--- test/can_regs_sva.sv
// Port-level assertions for the controller register block.
// Assumes one clock MCLK and synchronous active-high RST.
`timescale 1ns/1ps
module can_regs_sva (
    input wire logic       MCLK,
    input wire logic       RST,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       BUS_OFF,
    input wire logic       IN_RESET,
    input wire logic       ABORT_FRAME,
    input wire logic [4:0] CMD_PULSE,
    input wire logic [7:0] MODE_OUT,
    input wire logic [7:0] TIMING0,
    input wire logic [7:0] TIMING1,
    input wire logic [7:0] WARN_LIMIT,
    input wire logic       IRQ
);
    logic [4:0] cmd_bits;
    assign cmd_bits = WDATA[4:0];
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    // Leaving takes two steps: bit first, state one cycle later
    sequence leave_wr;
        WR && ADDR == 8'h00 && !WDATA[0] && IN_RESET && !BUS_OFF;
    endsequence
    chk_abort_entry: assert property (WR && ADDR == 8'h00 && WDATA[0] && !IN_RESET
        |=> IN_RESET && ABORT_FRAME) else $error("no abort on reset entry");
    chk_leave_reset: assert property (leave_wr ##1 !BUS_OFF
        |-> !MODE_OUT[0] ##1 !IN_RESET) else $error("reset mode not left");
    chk_hw_reset_vals: assert property ($fell(RST) |-> (MODE_OUT & 8'hBF) == 8'h01
        && WARN_LIMIT == 8'h60 && IN_RESET && !IRQ) else $error("bad values after reset");
    chk_bus_off_mode: assert property (BUS_OFF && !WR && !IN_RESET
        |=> MODE_OUT == (($past(MODE_OUT) & 8'h46) | 8'h01)) else $error("bad mode on bus off");
    chk_cmd_read_zero: assert property (RD && ADDR == 8'h01 |=> RDATA == 8'h00)
        else $error("command read not zero");
    chk_cmd_strobe: assert property (WR && ADDR == 8'h01 && !IN_RESET && !BUS_OFF
        |=> CMD_PULSE == $past(cmd_bits)) else $error("command strobe wrong");
    chk_timing_kept: assert property (BUS_OFF && !WR |=> $stable(TIMING0)
        && $stable(TIMING1) && $stable(WARN_LIMIT)) else $error("bus off changed timing");
    chk_timing_locked: assert property (WR && ADDR == 8'h06 && !IN_RESET
        |=> $stable(TIMING0)) else $error("timing written in run");
    chk_reserved_read: assert property (RD && ADDR == 8'h08 |=> RDATA == 8'h00)
        else $error("reserved read not zero");
endmodule : can_regs_sva
bind can_reset_mode_regs can_regs_sva can_regs_sva_inst (.*);

//--- test/can_core_model.sv
// Behavioural model of the protocol core feeding events to the registers.
// Assumes event pulses last exactly one MCLK cycle.
`timescale 1ns/1ps
module can_core_model (
    input wire logic       MCLK,
    output logic           BUS_OFF,
    output logic     [7:0] STATUS_SET,
    output logic     [7:0] STATUS_CLR,
    output logic     [7:0] IRQ_EVENTS,
    output logic           FIFO_WE,
    output logic     [5:0] FIFO_WADDR,
    output logic     [7:0] FIFO_WDATA,
    output logic     [5:0] RX_START
);
    // Core RAM writes stay idle: the host fills RAM in reset mode
    initial begin
        {BUS_OFF, STATUS_SET, STATUS_CLR, IRQ_EVENTS} = '0;
        {FIFO_WE, FIFO_WADDR, FIFO_WDATA, RX_START} = '0;
    end
    task evt(input logic bo, input logic [7:0] ss, input logic [7:0] ev);
        @(posedge MCLK);
        BUS_OFF <= bo;
        STATUS_SET <= ss;
        IRQ_EVENTS <= ev;
        @(posedge MCLK);
        BUS_OFF <= 1'b0;
        STATUS_SET <= 8'h00;
        IRQ_EVENTS <= 8'h00;
    endtask : evt
    task start(input logic [5:0] s);
        @(posedge MCLK);
        RX_START <= s;
    endtask : start
endmodule : can_core_model

//--- test/can_reset_mode_regs_tb.sv
// Self-checking bench for the controller register block.
// Assumes the core model drives all event inputs.
`timescale 1ns/1ps
module can_reset_mode_regs_tb;
    logic       MCLK, RST, WR, RD, BUS_OFF, FIFO_WE, IN_RESET, ABORT_FRAME, CAN_IRQ, IRQ;
    logic [7:0] ADDR, WDATA, RDATA, STATUS_SET, STATUS_CLR, IRQ_EVENTS, FIFO_WDATA;
    logic [7:0] MODE_OUT, TIMING0, TIMING1, WARN_LIMIT, RX_THRESHOLD;
    logic [5:0] FIFO_WADDR, RX_START;
    logic [4:0] CMD_PULSE;
    int         n_fail;
    int         comparisons;
    can_reset_mode_regs #(.FIFO_DEPTH(64)) can_reset_mode_regs_inst (.*);
    can_core_model can_core_model_inst (.*);
    initial begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end
    task chk(input logic [7:0] id, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] item %h expected %h seen %h", id, e, s);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        @(posedge MCLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge MCLK);
        RD <= 1'b0;
        #1 chk(a, RDATA & m, e);
    endtask : rd
    task close_out;
        if (n_fail == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    // Undefined pulse bit after power-up is masked out
    task hw_reset;
        RST <= 1'b1;
        repeat (6) @(posedge MCLK);
        RST <= 1'b0;
        rd(8'h00, 8'h01, 8'hBF);
        rd(8'h02, 8'h3C);
        rd(8'h03, 8'h00);
        rd(8'h0D, 8'h60);
        rd(8'h05, 8'h00);
    endtask : hw_reset
    initial begin
        {RST, WR, RD, ADDR, WDATA} = {1'b1, 18'h0_0000};
        n_fail = 0;
        comparisons = 0;
        hw_reset();
        rd(8'h01, 8'h00);
        wr(8'h08, 8'hFF);
        rd(8'h08, 8'h00);
        wr(8'h06, 8'hC5);
        wr(8'h07, 8'hA7);
        wr(8'h04, 8'hFF);
        wr(8'h85, 8'h5A);
        wr(8'h00, 8'h17);
        rd(8'h00, 8'h17);
        rd(8'h85, 8'h5A);
        wr(8'h00, 8'h06);
        rd(8'h00, 8'h06);
        can_core_model_inst.start(6'd3);
        wr(8'h85, 8'hEE);
        wr(8'h06, 8'h11);
        wr(8'h01, 8'h1F);
        #1 chk(8'h01, {3'h0, CMD_PULSE}, 8'h1F);
        rd(8'h82, 8'h5A);
        wr(8'h00, 8'h07);
        #1 chk(8'hA0, {7'h00, ABORT_FRAME}, 8'h01);
        chk(8'hA1, {7'h00, IN_RESET}, 8'h01);
        wr(8'h00, 8'h06);
        can_core_model_inst.evt(1'b0, 8'hFF, 8'hFF);
        can_core_model_inst.evt(1'b1, 8'h00, 8'h00);
        rd(8'h00, 8'h07);
        rd(8'h02, 8'h04);
        rd(8'h03, 8'h84);
        rd(8'h04, 8'hFF);
        rd(8'h06, 8'hC5);
        rd(8'h07, 8'hA7);
        wr(8'h11, 8'h00);
        #1 chk(8'h12, {7'h00, IRQ}, 8'h00);
        wr(8'h11, 8'h01);
        #1 chk(8'h12, {7'h00, IRQ}, 8'h01);
        wr(8'h10, 8'h01);
        #1 chk(8'h12, {7'h00, IRQ}, 8'h00);
        can_core_model_inst.evt(1'b0, 8'h00, 8'h84);
        #1 chk(8'hA2, {7'h00, CAN_IRQ}, 8'h01);
        hw_reset();
        chk(8'hA2, {7'h00, CAN_IRQ}, 8'h00);
        rd(8'h04, 8'hFF);
        rd(8'h06, 8'hC5);
        rd(8'h07, 8'hA7);
        close_out();
    end
    // Whole sequence needs about 100 cycles
    initial begin
        #50000;
        n_fail++;
        close_out();
    end
endmodule : can_reset_mode_regs_tb
